// ===== core/chan_gate.sv
`include "led_gate_consts.svh"
`default_nettype none
module chan_gate
  import led_gate_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        en_bit,
  input  wire logic        bypass,
  input  wire logic        enable_pin,
  input  wire logic        thermal_sd,
  input  wire chan_pins_t  pins,
  output logic             permit,
  output logic             gate_on
);

  gate_state_t state_reg;
  logic        dim_prev_reg;
  logic        boot_block_reg;
  logic        ready;

  // Bootstrap lockout holds until its comparator, which carries the hysteresis, releases.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      boot_block_reg <= 1'b1;
    end else begin
      boot_block_reg <= pins.boot_uv;
    end
  end

  // Lockouts are this channel's own; only the enable pin, bypass and thermal status are shared.
  // Fixed-threshold comparators arrive as plain flags with no adjustment path.
  // Bypass replaces only the enable bit; every other term stays.
  assign ready  = !pins.vcc_uv && !boot_block_reg && !pins.sense_uv && !thermal_sd && enable_pin
                  && (en_bit || bypass);
  assign permit = ready && pins.dim;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dim_prev_reg <= 1'b0;
    end else begin
      dim_prev_reg <= pins.dim;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= GATE_IDLE;
    end else begin
      case (state_reg)
        GATE_IDLE: begin
          if (ready) begin
            state_reg <= GATE_ARMED;
          end
        end
        GATE_ARMED: begin
          if (!ready) begin
            state_reg <= GATE_IDLE;
          end else if (pins.dim && !dim_prev_reg) begin
            state_reg <= GATE_ON;
          end
        end
        GATE_ON: begin
          if (!ready) begin
            state_reg <= GATE_IDLE;
          end else if (!pins.dim) begin
            state_reg <= GATE_ARMED;
          end
        end
        default: state_reg <= GATE_IDLE;
      endcase
    end
  end

  // Arming needs every term but the dim input; enabling while dim is already high waits for its next rising edge.
  assign gate_on = (state_reg == GATE_ON) && permit;

endmodule : chan_gate
`default_nettype wire

// ===== core/led_gate_top.sv
`include "led_gate_consts.svh"
`default_nettype none
module led_gate_top
  import led_gate_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        enable_undervoltage_pin,
  input  wire logic        serial_bypass_enable_level,
  input  wire logic        thermal_shutdown,
  input  wire logic [1:0]  channel_dim_input,
  input  wire logic [1:0]  vcc_undervoltage,
  input  wire logic [1:0]  boot_undervoltage,
  input  wire logic [1:0]  current_sense_positive_input,
  output logic [1:0]       gate_drive,
  output code_set_t        active_codes_0,
  output code_set_t        active_codes_1
);

  localparam int DLY = `APPLY_DELAY_CYC;

  // ------------------------------------------------------------
  // Pin synchronisation
  // ------------------------------------------------------------
  logic [10:0] pins_sync;

  sync2 #(.W(11)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({enable_undervoltage_pin, serial_bypass_enable_level, thermal_shutdown, channel_dim_input,
                vcc_undervoltage, boot_undervoltage, current_sense_positive_input}),
    .q       (pins_sync)
  );

  logic       en_pin_s;
  logic       bypass_s;
  logic       thermal_s;
  logic [1:0] dim_s;
  logic [1:0] vcc_uv_s;
  logic [1:0] boot_uv_s;
  logic [1:0] sense_uv_s;

  assign {en_pin_s, bypass_s, thermal_s, dim_s, vcc_uv_s, boot_uv_s, sense_uv_s} = pins_sync;

  // ------------------------------------------------------------
  // Register storage
  // ------------------------------------------------------------
  logic [1:0]  chan_en_reg;
  code_set_t   shadow_reg [2];
  code_set_t   active_reg [2];
  logic [7:0]  apply_cnt_reg;
  logic        apply_pend_reg;

  // ------------------------------------------------------------
  // AXI4-Lite write channel
  // ------------------------------------------------------------
  logic        aw_held_reg;
  logic [11:0] aw_addr_reg;
  logic        w_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        do_write;
  logic        wr_hit;

  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
  assign do_write      = aw_held_reg && w_held_reg && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_reg <= 1'b0;
    end
  end

  always_comb begin
    if (aw_addr_reg == `OFS_CTRL) begin
      wr_hit = 1'b1;
    end else if (aw_addr_reg == `OFS_STATUS) begin
      wr_hit = 1'b1;
    end else if (aw_addr_reg >= `OFS_PKTH0 && aw_addr_reg <= `OFS_MAXOFF1 && aw_addr_reg[1:0] == 2'b00) begin
      wr_hit = 1'b1;
    end else begin
      wr_hit = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `AXI_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chan_en_reg <= 2'b00;
    end else if (do_write && aw_addr_reg == `OFS_CTRL && w_strb_reg[0]) begin
      chan_en_reg <= {w_data_reg[`CTRL_EN1_BIT], w_data_reg[`CTRL_EN0_BIT]};
    end
  end

  // Codes land in a shadow copy at the write; any value, zero included, is accepted as written.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shadow_reg[0] <= '{peak: `CODE_RESET, off_time: `CODE_RESET, max_off: `CODE_RESET};
      shadow_reg[1] <= '{peak: `CODE_RESET, off_time: `CODE_RESET, max_off: `CODE_RESET};
    end else if (do_write && w_strb_reg[0]) begin
      if (aw_addr_reg == `OFS_PKTH0) begin
        shadow_reg[0].peak <= w_data_reg[7:0];
      end else if (aw_addr_reg == `OFS_TOFF0) begin
        shadow_reg[0].off_time <= w_data_reg[7:0];
      end else if (aw_addr_reg == `OFS_MAXOFF0) begin
        shadow_reg[0].max_off <= w_data_reg[7:0];
      end else if (aw_addr_reg == `OFS_PKTH1) begin
        shadow_reg[1].peak <= w_data_reg[7:0];
      end else if (aw_addr_reg == `OFS_TOFF1) begin
        shadow_reg[1].off_time <= w_data_reg[7:0];
      end else if (aw_addr_reg == `OFS_MAXOFF1) begin
        shadow_reg[1].max_off <= w_data_reg[7:0];
      end
    end
  end

  // ------------------------------------------------------------
  // Delayed application of thresholds
  // ------------------------------------------------------------
  // A write restarts the delay so the newest value is applied DLY cycles after the last transaction.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      apply_pend_reg <= 1'b0;
      apply_cnt_reg  <= 8'h00;
    end else if (do_write) begin
      apply_pend_reg <= 1'b1;
      apply_cnt_reg  <= 8'(DLY);
    end else if (apply_pend_reg) begin
      if (apply_cnt_reg == 8'h01) begin
        apply_pend_reg <= 1'b0;
      end
      apply_cnt_reg <= apply_cnt_reg - 8'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active_reg[0] <= '{peak: `CODE_RESET, off_time: `CODE_RESET, max_off: `CODE_RESET};
      active_reg[1] <= '{peak: `CODE_RESET, off_time: `CODE_RESET, max_off: `CODE_RESET};
    end else if (apply_pend_reg && apply_cnt_reg == 8'h01) begin
      active_reg[0] <= shadow_reg[0];
      active_reg[1] <= shadow_reg[1];
    end
  end

  assign active_codes_0 = active_reg[0];
  assign active_codes_1 = active_reg[1];

  // ------------------------------------------------------------
  // Per-channel gating
  // ------------------------------------------------------------
  logic [1:0] permit;
  logic [1:0] gate_next;
  logic [1:0] gate_reg;

  for (genvar c = 0; c < 2; c++) begin : g_chan
    chan_gate u_gate (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .en_bit     (chan_en_reg[c]),
      .bypass     (bypass_s),
      .enable_pin (en_pin_s),
      .thermal_sd (thermal_s),
      .pins       (chan_pins_t'{vcc_uv: vcc_uv_s[c], boot_uv: boot_uv_s[c], sense_uv: sense_uv_s[c], dim: dim_s[c]}),
      .permit     (permit[c]),
      .gate_on    (gate_next[c])
    );
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gate_reg <= 2'b00;
    end else begin
      gate_reg <= gate_next;
    end
  end

  assign gate_drive = gate_reg;

  // ------------------------------------------------------------
  // AXI4-Lite read channel
  // ------------------------------------------------------------
  logic [31:0] rd_mux;
  logic        rd_hit;

  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    if (s_axi_araddr == `OFS_CTRL) begin
      rd_mux = {30'h0000_0000, chan_en_reg};
    end else if (s_axi_araddr == `OFS_STATUS) begin
      rd_mux = {16'h0000, gate_reg, permit, dim_s, vcc_uv_s, boot_uv_s, sense_uv_s, en_pin_s, bypass_s,
                thermal_s, apply_pend_reg};
    end else if (s_axi_araddr == `OFS_PKTH0) begin
      rd_mux = {24'h00_0000, shadow_reg[0].peak};
    end else if (s_axi_araddr == `OFS_TOFF0) begin
      rd_mux = {24'h00_0000, shadow_reg[0].off_time};
    end else if (s_axi_araddr == `OFS_MAXOFF0) begin
      rd_mux = {24'h00_0000, shadow_reg[0].max_off};
    end else if (s_axi_araddr == `OFS_PKTH1) begin
      rd_mux = {24'h00_0000, shadow_reg[1].peak};
    end else if (s_axi_araddr == `OFS_TOFF1) begin
      rd_mux = {24'h00_0000, shadow_reg[1].off_time};
    end else if (s_axi_araddr == `OFS_MAXOFF1) begin
      rd_mux = {24'h00_0000, shadow_reg[1].max_off};
    end else begin
      rd_hit = 1'b0;
    end
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `AXI_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : led_gate_top
`default_nettype wire

// ===== core/sync2.sv
`default_nettype none
module sync2
  import led_gate_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule : sync2
`default_nettype wire

// ===== include/led_gate_consts.svh
// Overview of operation
// - A channel switches only while its supply, bootstrap and sense lockouts are clear, no thermal shutdown, and the enable pin is high.
// - A channel also needs its dimming input high, and no register setting can override that.
// - A high-level bypass input overrides the channel enable bit and treats the channel as enabled.
// - After reset the peak threshold and off-time codes hold midscale 127 out of 255.
// - With the high-level bypass active, every other enable condition is still required.
// - New thresholds may be written at any time and reach regulation about 100 ns after the write completes.
// - Supply lockout acts per channel, so one channel's lockout leaves the other running.
// - Supply lockout thresholds are fixed and no register or pin adjusts them.
// - A bootstrap lockout stops switching until the bootstrap supply has recovered by its hysteresis.
// - A low dimming input disables the gate logic and a rising edge sets the gate latch and turns the switch on.
// - The on-time ends when the dimming pulse ends and a new one starts at the next rising edge.
`ifndef LED_GATE_CONSTS_SVH
`define LED_GATE_CONSTS_SVH

`define CLK_PERIOD_NS      10
`define APPLY_DELAY_NS     100
`define APPLY_DELAY_CYC    ((`APPLY_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CODE_RESET         8'h7f

`define OFS_CTRL           12'h000
`define OFS_STATUS         12'h004
`define OFS_PKTH0          12'h008
`define OFS_TOFF0          12'h00c
`define OFS_MAXOFF0        12'h010
`define OFS_PKTH1          12'h014
`define OFS_TOFF1          12'h018
`define OFS_MAXOFF1        12'h01c

`define CTRL_EN0_BIT       0
`define CTRL_EN1_BIT       1

`define AXI_RESP_OKAY      2'b00
`define AXI_RESP_SLVERR    2'b10

`endif

// ===== include/led_gate_pkg.sv
`default_nettype none
package led_gate_pkg;

  typedef struct packed {
    logic [7:0] peak;
    logic [7:0] off_time;
    logic [7:0] max_off;
  } code_set_t;

  typedef struct packed {
    logic vcc_uv;
    logic boot_uv;
    logic sense_uv;
    logic dim;
  } chan_pins_t;

  typedef enum logic [1:0] {
    GATE_IDLE,
    GATE_ARMED,
    GATE_ON
  } gate_state_t;

endpackage : led_gate_pkg
`default_nettype wire

// ===== sim/led_gate_assertions.sv
`default_nettype none
module led_gate_assertions
  import led_gate_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_bvalid,
  input wire logic        enable_undervoltage_pin,
  input wire logic        thermal_shutdown,
  input wire logic [1:0]  channel_dim_input,
  input wire logic [1:0]  vcc_undervoltage,
  input wire logic [1:0]  boot_undervoltage,
  input wire logic [1:0]  current_sense_positive_input,
  input wire logic [1:0]  gate_drive,
  input wire code_set_t   active_codes_0,
  input wire code_set_t   active_codes_1
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] since_b;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------
  // Cycles since the last write response rose.
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) since_b <= 4'hf;
    else if ($rose(s_axi_bvalid)) since_b <= 4'h0;
    else if (since_b != 4'hf) since_b <= since_b + 4'h1;
  end
  codes_reset_a: assert property ($rose(aresetn) |-> active_codes_0 == {3{8'h7f}} && active_codes_1 == {3{8'h7f}})
    else $error("codes not midscale after reset");
  dim_gate_a: assert property (!channel_dim_input[0] [*6] |=> !gate_drive[0])
    else $error("gate on with dim low");
  thermal_off_a: assert property (thermal_shutdown [*6] |=> gate_drive == 2'b00)
    else $error("gate on in thermal shutdown");
  pin_off_a: assert property (!enable_undervoltage_pin [*6] |=> gate_drive == 2'b00)
    else $error("gate on with enable pin low");
  vcc_chan_a: assert property (vcc_undervoltage[0] [*6] |=> !gate_drive[0])
    else $error("gate on in supply lockout");
  boot_off_a: assert property (boot_undervoltage[1] [*7] |=> !gate_drive[1])
    else $error("gate on in bootstrap lockout");
  sense_off_a: assert property (current_sense_positive_input[0] [*6] |=> !gate_drive[0])
    else $error("gate on in sense lockout");
  apply_delay_a: assert property ($changed(active_codes_0) |-> since_b >= 4'd7 && since_b <= 4'd9)
    else $error("codes applied at wrong time");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule : led_gate_assertions
bind led_gate_top led_gate_assertions u_chk (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .s_axi_bvalid, .enable_undervoltage_pin, .thermal_shutdown, .channel_dim_input,
  .vcc_undervoltage, .boot_undervoltage, .current_sense_positive_input, .gate_drive, .active_codes_0,
  .active_codes_1);
`default_nettype wire

// ===== sim/led_gate_top_tb.sv
`include "led_gate_consts.svh"
`default_nettype none
module led_gate_top_tb import led_gate_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic        aclk = 1'b0, aresetn = 1'b0, enable_undervoltage_pin = 1'b1;
  logic        serial_bypass_enable_level = 1'b0, thermal_shutdown = 1'b0;
  logic [1:0]  vcc_undervoltage = 2'b00, boot_undervoltage = 2'b00, current_sense_positive_input = 2'b00;
  logic [1:0]  channel_dim_input, gate_drive, s_axi_bresp, s_axi_rresp, r, en;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  code_set_t   active_codes_0, active_codes_1, exp_c;
  int          bad_count = 0, tests_run = 0;
  always #5 aclk = ~aclk;
  led_gate_top dut (.*);
  mcu_model mcu (.*);
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %0t %s", $time, m);
    end
  endtask : chk
  function automatic logic exp_gate(input int c);
    return !vcc_undervoltage[c] && !boot_undervoltage[c] && !current_sense_positive_input[c]
      && !thermal_shutdown && enable_undervoltage_pin && (en[c] || serial_bypass_enable_level);
  endfunction : exp_gate
  task automatic pulse(input string m);
    @(posedge aclk) mcu.channel_dim_input <= 2'b00;
    tick(8);
    mcu.channel_dim_input <= 2'b11;
    tick(8);
    chk(gate_drive, {exp_gate(1), exp_gate(0)}, m);
    mcu.channel_dim_input <= 2'b00;
    tick(8);
    chk(gate_drive, 2'b00, m);
  endtask : pulse
  task automatic tally_and_finish();
    if (bad_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  // ----------------------------------------
  // Main sequence.
  // ----------------------------------------
  initial begin
    void'($urandom(32'h1764));
    tick(12);
    aresetn <= 1'b1;
    tick(2);
    chk(active_codes_0, {3{8'h7f}}, "active codes reset");
    for (int i = 0; i < 6; i++) begin
      mcu.rd(12'(`OFS_PKTH0 + 4 * i), d, r);
      chk(d[7:0], `CODE_RESET, "code register reset");
    end
    mcu.channel_dim_input <= 2'b11;
    en = 2'b11;
    mcu.wr(`OFS_CTRL, 32'h3, r);
    tick(10);
    chk(gate_drive, 2'b00, "switched without dim edge");
    pulse("dim edge");
    repeat (40) begin
      en = 2'($urandom);
      mcu.wr(`OFS_CTRL, {30'h0, en}, r);
      enable_undervoltage_pin <= ($urandom % 5) != 0;
      thermal_shutdown <= ($urandom % 6) == 0;
      serial_bypass_enable_level <= 1'($urandom);
      vcc_undervoltage <= {$urandom % 4 == 0, $urandom % 4 == 0};
      boot_undervoltage <= {$urandom % 4 == 0, $urandom % 4 == 0};
      current_sense_positive_input <= {$urandom % 4 == 0, $urandom % 4 == 0};
      pulse("gating");
    end
    {enable_undervoltage_pin, thermal_shutdown, serial_bypass_enable_level} <= 3'b100;
    {vcc_undervoltage, boot_undervoltage, current_sense_positive_input} <= '0;
    for (int c = 0; c < 2; c++) begin
      exp_c.peak = 8'($urandom_range(255, 1));
      exp_c.off_time = 8'($urandom_range(255, 55));
      exp_c.max_off = 8'($urandom_range(64005, 251) / 251);
      mcu.wr(12'(`OFS_PKTH0 + 12 * c), {24'h0, exp_c.peak}, r);
      mcu.wr(12'(`OFS_TOFF0 + 12 * c), {24'h0, exp_c.off_time}, r);
      mcu.wr(12'(`OFS_MAXOFF0 + 12 * c), {24'h0, exp_c.max_off}, r);
      tick(12);
      chk(c ? active_codes_1 : active_codes_0, exp_c, "codes applied");
      mcu.rd(12'(`OFS_MAXOFF0 + 12 * c), d, r);
      chk(d[7:0], exp_c.max_off, "code readback");
    end
    mcu.wr(12'h020, 32'h0, r);
    chk(r, `AXI_RESP_SLVERR, "unmapped write");
    mcu.rd(12'h020, d, r);
    chk(r, `AXI_RESP_SLVERR, "unmapped read");
    mcu.wr(`OFS_STATUS, 32'hffff, r);
    chk(r, `AXI_RESP_OKAY, "status write");
    @(posedge aclk) aresetn <= 1'b0;
    tick(3);
    aresetn <= 1'b1;
    tick(2);
    chk(active_codes_1, {3{8'h7f}}, "codes after second reset");
    en = 2'b00;
    pulse("enables cleared");
    serial_bypass_enable_level <= 1'b1;
    pulse("bypass");
    tally_and_finish();
  end
  initial begin
    #500000;
    bad_count++;
    tally_and_finish();
  end
endmodule : led_gate_top_tb
`default_nettype wire

// ===== sim/mcu_model.sv
`default_nettype none
module mcu_model (
  input  wire logic        aclk,
  input  wire logic        s_axi_awready,
  input  wire logic        s_axi_wready,
  input  wire logic        s_axi_bvalid,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_arready,
  input  wire logic        s_axi_rvalid,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  output var  logic [11:0] s_axi_awaddr,
  output var  logic        s_axi_awvalid,
  output var  logic [31:0] s_axi_wdata,
  output var  logic [3:0]  s_axi_wstrb,
  output var  logic        s_axi_wvalid,
  output var  logic        s_axi_bready,
  output var  logic [11:0] s_axi_araddr,
  output var  logic        s_axi_arvalid,
  output var  logic        s_axi_rready,
  output var  logic [1:0]  channel_dim_input
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    channel_dim_input = 2'b00;
  end
  // ----------------------------------------
  // Bus cycles; released lines show the inverse so stale values never pass.
  // ----------------------------------------
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
      if (!s_axi_bready) s_axi_bready <= 1'($urandom_range(1, 0));
    end while (!(s_axi_bvalid && s_axi_bready));
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
      end
      if (!s_axi_rready) s_axi_rready <= 1'($urandom_range(1, 0));
    end while (!(s_axi_rvalid && s_axi_rready));
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : mcu_model
`default_nettype wire
